// *** rtl/sample_rate_pkg.sv ***
// constants, field layout and states for the sample rate scheduler
package sample_rate_pkg;

    localparam logic [7:0]  RATE_SELECT_ADDR  = 8'h17;
    localparam int          AWAKE_NIBBLE_LSB  = 4;
    localparam int          ASLEEP_NIBBLE_LSB = 0;
    localparam logic [7:0]  RESET_BOOT_GND    = 8'h00;
    localparam logic [7:0]  RESET_BOOT_VDD    = 8'hC0;
    localparam logic [1:0]  PM_LOW_POWER      = 2'h0;
    localparam logic [1:0]  PM_HIGH_PERF      = 2'h1;
    localparam logic [3:0]  CODE_CAP          = 4'hC;
    localparam int          IDLE_MSB_BITS     = 4;
    localparam int          COUNT_W           = 40;

    localparam real         CLK_PERIOD_NS     = 10.0;
    localparam real         BASE_TIME_US      = 312.5;
    localparam real         FIRST_TIME_US     = 528.5;
    localparam real         FIRST_FACTOR      = 0.9984;
    localparam real         GAP_TIME_US       = 500.0;
    localparam real         PULSE_TIME_MS     = 5.0;

    localparam int unsigned BASE_CYCLES  = int'($ceil(BASE_TIME_US * 1000.0 / CLK_PERIOD_NS));
    localparam int unsigned FIRST_CYCLES = int'($ceil(FIRST_TIME_US * 1000.0 / CLK_PERIOD_NS));
    localparam int unsigned FIRST_STEP   = int'($ceil(FIRST_FACTOR * BASE_TIME_US * 1000.0 / CLK_PERIOD_NS));
    localparam int unsigned GAP_CYCLES   = int'($ceil(GAP_TIME_US * 1000.0 / CLK_PERIOD_NS));
    localparam int unsigned PULSE_CYCLES = int'($ceil(PULSE_TIME_MS * 1000000.0 / CLK_PERIOD_NS));

    typedef enum logic [1:0] {
        ST_STANDBY = 2'h0,
        ST_FIRST   = 2'h1,
        ST_RUN     = 2'h3,
        ST_GAP     = 2'h2
    } sched_state_e;

endpackage

// *** rtl/pulse_timer.sv ***
// retriggerable fixed-width pulse timer
`timescale 1ns/1ps
module pulse_timer #(
    parameter int unsigned CYCLES = 500000
) (
    input  wire logic clk,     // system clock
    input  wire logic rst_b,   // synchronous reset, active low
    input  wire logic trigger, // start or restart the pulse
    output logic      busy     // high while the pulse runs
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (trigger) begin
            next_count = W'(CYCLES);
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
endmodule

// *** rtl/sample_rate_scheduler.sv ***
// sample rate and decimation scheduler with rate select register
`timescale 1ns/1ps
module sample_rate_scheduler
    import sample_rate_pkg::*;
#(
    parameter int unsigned BASE_CYC  = BASE_CYCLES,
    parameter int unsigned FIRST_CYC = FIRST_CYCLES,
    parameter int unsigned STEP_CYC  = FIRST_STEP,
    parameter int unsigned GAP_CYC   = GAP_CYCLES,
    parameter int unsigned PULSE_CYC = PULSE_CYCLES
) (
    input  wire logic       clk,                 // 100 MHz clock
    input  wire logic       rst_b,               // synchronous reset, active low
    input  wire logic       boot_mode_pin,       // boot strap, high = tied to supply
    input  wire logic       reg_wr,              // register write strobe
    input  wire logic [7:0] reg_addr,            // register address
    input  wire logic [7:0] reg_wdata,           // register write data
    output logic      [7:0] reg_rdata,           // register read data
    input  wire logic       active,              // active measurement enable
    input  wire logic       asleep,              // 1 = asleep state, 0 = awake
    input  wire logic [1:0] awake_power_select,  // awake power mode field
    input  wire logic [1:0] asleep_power_select, // asleep power mode field
    input  wire logic [7:0] awake_idle_msb,      // awake idle count, high byte
    input  wire logic [7:0] awake_idle_lsb,      // awake idle count, low byte
    input  wire logic [7:0] asleep_idle_msb,     // asleep idle count, high byte
    input  wire logic [7:0] asleep_idle_lsb,     // asleep idle count, low byte
    input  wire logic       ready_irq_enable,    // sample ready interrupt enable
    output logic            sample_ready_event,  // one-cycle pulse per acquisition
    output logic [12:0]     decimation,          // decimation in use
    output logic [1:0]      scheduler_state,     // scheduler state
    output logic            first_interrupt_out, // interrupt line drive value
    output logic            first_interrupt_oe_b // interrupt line enable, low drives
);

    ////////////////////////////////////////////////////////////////////////////
    // rate select register
    logic [7:0] rate_select;
    logic [7:0] next_rate_select;
    logic [7:0] next_rdata;

    always_comb begin
        next_rate_select = rate_select;
        if (reg_wr && reg_addr == RATE_SELECT_ADDR) begin
            next_rate_select = reg_wdata;
        end
        next_rdata = (reg_addr == RATE_SELECT_ADDR) ? rate_select : 8'h00;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rate_select <= boot_mode_pin ? RESET_BOOT_VDD : RESET_BOOT_GND;
            reg_rdata   <= 8'h00;
        end else begin
            rate_select <= next_rate_select;
            reg_rdata   <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // period arithmetic
    function automatic logic [3:0] code_shift(input logic [3:0] code);
        code_shift = (code > CODE_CAP) ? CODE_CAP : code;
    endfunction

    function automatic logic [12:0] calc_decim(input logic [1:0] pm, input logic [3:0] code);
        calc_decim = (pm == PM_LOW_POWER) ? 13'h1 : (13'h1 << code_shift(code));
    endfunction

    function automatic logic [COUNT_W-1:0] calc_period(input logic [1:0] pm, input logic [3:0] code,
                                                       input logic [11:0] idle);
        logic [COUNT_W-1:0] mult;
        mult = pm[1] ? {27'h0, {1'b0, idle} + 13'h1} : 40'h1;
        calc_period = (mult * COUNT_W'(BASE_CYC)) << code_shift(code);
    endfunction

    function automatic logic is_fast(input logic [1:0] pm, input logic [3:0] code, input logic [11:0] idle);
        is_fast = pm[1] ? (idle == 12'h0) : (code == 4'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // selected state configuration
    logic [1:0]  sel_pm;
    logic [3:0]  sel_code;
    logic [11:0] sel_idle;

    always_comb begin
        sel_pm   = asleep ? asleep_power_select : awake_power_select;
        sel_code = asleep ? rate_select[ASLEEP_NIBBLE_LSB +: 4] : rate_select[AWAKE_NIBBLE_LSB +: 4];
        sel_idle = asleep ? {asleep_idle_msb[IDLE_MSB_BITS-1:0], asleep_idle_lsb}
                          : {awake_idle_msb[IDLE_MSB_BITS-1:0], awake_idle_lsb};
    end

    ////////////////////////////////////////////////////////////////////////////
    // scheduler state machine
    sched_state_e       state;
    sched_state_e       next_state;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic               cur_asleep;
    logic               next_cur_asleep;
    logic [1:0]         cur_pm;
    logic [1:0]         next_cur_pm;
    logic [3:0]         cur_code;
    logic [3:0]         next_cur_code;
    logic [11:0]        cur_idle;
    logic [11:0]        next_cur_idle;
    logic               next_strobe;
    logic [COUNT_W-1:0] cur_period;
    logic [COUNT_W-1:0] sel_period;
    logic [COUNT_W-1:0] first_delay;
    logic [12:0]        sel_decim;

    always_comb begin
        cur_period  = calc_period(cur_pm, cur_code, cur_idle);
        sel_period  = calc_period(sel_pm, sel_code, sel_idle);
        sel_decim   = calc_decim(sel_pm, sel_code);
        first_delay = COUNT_W'(FIRST_CYC) + COUNT_W'(STEP_CYC) * {27'h0, sel_decim - 13'h1};
    end

    always_comb begin
        next_state      = state;
        next_count      = count;
        next_cur_asleep = cur_asleep;
        next_cur_pm     = cur_pm;
        next_cur_code   = cur_code;
        next_cur_idle   = cur_idle;
        next_strobe     = 1'b0;
        if (!active) begin
            next_state = ST_STANDBY;
            next_count = '0;
        end else begin
            case (state)
                ST_STANDBY: begin
                    next_cur_asleep = asleep;
                    next_cur_pm     = sel_pm;
                    next_cur_code   = sel_code;
                    next_cur_idle   = sel_idle;
                    next_count      = is_fast(sel_pm, sel_code, sel_idle) ? first_delay - 40'h1
                                                                          : sel_period - 40'h1;
                    next_state      = ST_FIRST;
                end
                ST_FIRST, ST_RUN, ST_GAP: begin
                    if (state != ST_FIRST && asleep != cur_asleep) begin
                        next_cur_asleep = asleep;
                        next_cur_pm     = sel_pm;
                        next_cur_code   = sel_code;
                        next_cur_idle   = sel_idle;
                        next_count      = COUNT_W'(GAP_CYC) - 40'h1;
                        next_state      = ST_GAP;
                    end else if (count == '0) begin
                        next_strobe = 1'b1;
                        next_count  = cur_period - 40'h1;
                        next_state  = ST_RUN;
                    end else begin
                        next_count = count - 40'h1;
                    end
                end
                default: begin
                    next_state = ST_STANDBY;
                    next_count = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state              <= ST_STANDBY;
            count              <= '0;
            cur_asleep         <= 1'b0;
            cur_pm             <= PM_LOW_POWER;
            cur_code           <= 4'h0;
            cur_idle           <= 12'h000;
            sample_ready_event <= 1'b0;
        end else begin
            state              <= next_state;
            count              <= next_count;
            cur_asleep         <= next_cur_asleep;
            cur_pm             <= next_cur_pm;
            cur_code           <= next_cur_code;
            cur_idle           <= next_cur_idle;
            sample_ready_event <= next_strobe;
        end
    end

    assign decimation      = calc_decim(cur_pm, cur_code);
    assign scheduler_state = state;

    ////////////////////////////////////////////////////////////////////////////
    // motion boot ready pulse on the first interrupt line
    logic pulse_busy;

    pulse_timer #(
        .CYCLES (PULSE_CYC)
    ) u_ready_pulse (
        .clk     (clk),
        .rst_b   (rst_b),
        .trigger (sample_ready_event && boot_mode_pin && ready_irq_enable),
        .busy    (pulse_busy)
    );

    assign first_interrupt_out  = 1'b0;
    assign first_interrupt_oe_b = ~pulse_busy;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_reset_value: assert property (@(posedge clk) !$past(rst_b) && rst_b |->
        rate_select == ($past(boot_mode_pin) ? 8'hC0 : 8'h00)) else $error("rate select reset value wrong");
    a_write_stores: assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == 8'h17 |=> rate_select == $past(reg_wdata)) else $error("rate select write lost");
    a_lpm_slowest: assert property (@(posedge clk) disable iff (!rst_b)
        cur_pm == 2'h0 && cur_code == 4'hE |-> cur_period == 40'(BASE_CYC) * 40'd4096 && decimation == 13'd1)
        else $error("low power slowest period wrong");
    a_hpm_decim: assert property (@(posedge clk) disable iff (!rst_b)
        cur_pm == 2'h1 |-> decimation == ((cur_code >= 4'hC) ? 13'd4096 : 13'd1 << cur_code))
        else $error("high performance decimation wrong");
    a_fpm_period: assert property (@(posedge clk) disable iff (!rst_b)
        cur_pm[1] && cur_code == 4'h1 |-> cur_period == 40'(BASE_CYC) * 40'd2 * ({28'h0, cur_idle} + 40'd1))
        else $error("flexible period wrong");
    a_first_delay: assert property (@(posedge clk) disable iff (!rst_b)
        state == ST_STANDBY && active && sel_pm == 2'h0 && sel_code == 4'h0 |=> count == 40'(FIRST_CYC) - 40'd1)
        else $error("first sample delay wrong");
    a_run_spacing: assert property (@(posedge clk) disable iff (!rst_b)
        sample_ready_event |=> !sample_ready_event[*3])
        else $error("samples too close");
    a_gap_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        state != ST_GAP ##1 state == ST_GAP |-> (!next_strobe)[*8]) else $error("sample inside switch gap");
    a_load_config: assert property (@(posedge clk) disable iff (!rst_b)
        state == ST_GAP |-> cur_code == (cur_asleep ? rate_select[3:0] : rate_select[7:4]))
        else $error("new state config not loaded");
    a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        sample_ready_event && boot_mode_pin && ready_irq_enable |=> !first_interrupt_oe_b[*8])
        else $error("ready pulse missing");

    c_first_sample: cover property (@(posedge clk) disable iff (!rst_b) state == ST_FIRST ##1 state == ST_RUN);
    c_state_switch: cover property (@(posedge clk) disable iff (!rst_b) state == ST_GAP ##1 state == ST_RUN);
    c_flex_run:     cover property (@(posedge clk) disable iff (!rst_b) sample_ready_event && cur_pm[1]);
    c_ready_pulse:  cover property (@(posedge clk) disable iff (!rst_b) $fell(first_interrupt_oe_b));
endmodule

// *** tb/host_model.sv ***
// host side model: register access and measurement enable
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,       // system clock
    output logic            reg_wr,    // write strobe
    output logic      [7:0] reg_addr,  // register address
    output logic      [7:0] reg_wdata, // write data
    input  wire logic [7:0] reg_rdata, // read data
    output logic            active     // measurement enable
);
    initial begin
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        active    = 1'b0;
    end
    // codes are only rewritten in standby
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        if (active !== 1'b0) begin
            @(posedge clk);
            active <= 1'b0;
        end
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
    task automatic set_active(input logic v);
        @(posedge clk);
        active <= v;
    endtask
endmodule

// *** tb/sample_rate_scheduler_test.sv ***
// self-checking bench for the sample rate scheduler
`timescale 1ns/1ps
module sample_rate_scheduler_test;
    import sample_rate_pkg::*;
    localparam int BASE = 4;
    localparam int FIRST = 6;
    localparam int STEP = 3;
    localparam int GAP = 10;
    localparam int PULSE = 10;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        boot_mode_pin = 1'b0;
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        active;
    logic        asleep = 1'b0;
    logic [1:0]  awake_power_select = 2'h0;
    logic [1:0]  asleep_power_select = 2'h0;
    logic [7:0]  awake_idle_msb = 8'h00;
    logic [7:0]  awake_idle_lsb = 8'h00;
    logic [7:0]  asleep_idle_msb = 8'h00;
    logic [7:0]  asleep_idle_lsb = 8'h00;
    logic        ready_irq_enable = 1'b0;
    logic        sample_ready_event;
    logic [12:0] decimation;
    logic [1:0]  scheduler_state;
    logic        first_interrupt_out;
    logic        first_interrupt_oe_b;
    logic [31:0] seed = 32'hA97CF1ED;
    int          failures = 0;
    int          compares = 0;

    always #5 clk = ~clk;

    host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_rdata(reg_rdata), .active(active));
    sample_rate_scheduler #(.BASE_CYC(BASE), .FIRST_CYC(FIRST), .STEP_CYC(STEP), .GAP_CYC(GAP),
                            .PULSE_CYC(PULSE)) dut_u (
        .clk(clk), .rst_b(rst_b), .boot_mode_pin(boot_mode_pin), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .active(active), .asleep(asleep),
        .awake_power_select(awake_power_select), .asleep_power_select(asleep_power_select),
        .awake_idle_msb(awake_idle_msb), .awake_idle_lsb(awake_idle_lsb), .asleep_idle_msb(asleep_idle_msb),
        .asleep_idle_lsb(asleep_idle_lsb), .ready_irq_enable(ready_irq_enable),
        .sample_ready_event(sample_ready_event), .decimation(decimation), .scheduler_state(scheduler_state),
        .first_interrupt_out(first_interrupt_out), .first_interrupt_oe_b(first_interrupt_oe_b));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int dec(logic [1:0] pm, logic [3:0] code);
        return (pm == PM_LOW_POWER) ? 1 : 1 << ((code > CODE_CAP) ? 12 : code);
    endfunction
    function automatic int period(logic [1:0] pm, logic [3:0] code, logic [11:0] idle);
        return (BASE << ((code > CODE_CAP) ? 12 : code)) * (pm[1] ? idle + 1 : 1);
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_reset(input logic b);
        @(posedge clk);
        boot_mode_pin <= b;
        rst_b         <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    task automatic wait_event(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (sample_ready_event !== 1'b1 && n < 40000);
    endtask
    task automatic set_state(input logic slp, input logic [1:0] pm, input logic [11:0] idle);
        logic [31:0] r;
        r = xs();
        @(posedge clk);
        asleep <= slp;
        if (slp) begin
            asleep_power_select <= pm;
            asleep_idle_msb     <= {r[3:0], idle[11:8]};
            asleep_idle_lsb     <= idle[7:0];
        end else begin
            awake_power_select <= pm;
            awake_idle_msb     <= {r[3:0], idle[11:8]};
            awake_idle_lsb     <= idle[7:0];
        end
    endtask
    task automatic run_case(input logic [1:0] pm, input logic [3:0] code, input logic [11:0] idle, input logic slp);
        int n;
        int e;
        logic [7:0] wv;
        logic [7:0] rv;
        logic [31:0] r;
        r  = xs();
        wv = slp ? {r[3:0], code} : {code, r[3:0]};
        host_u.write_reg(RATE_SELECT_ADDR, wv);
        host_u.read_reg(RATE_SELECT_ADDR, rv);
        check("rate_select", rv, wv);
        set_state(!slp, r[5:4], 12'(r[15:8]));
        set_state(slp, pm, idle);
        host_u.set_active(1'b1);
        wait_event(n);
        e = FIRST + STEP * (dec(pm, code) - 1) + 1;
        if (pm[1] ? idle == 0 : code == 0) check("first_fast", n >= e && n <= e + 1, 1'b1);
        else check("first_slow", n >= 1 && n <= period(pm, code, idle) + 2, 1'b1);
        check("decimation", decimation, dec(pm, code));
        wait_event(n);
        check("period", n, period(pm, code, idle));
        host_u.set_active(1'b0);
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end

    initial begin
        int n;
        int k;
        logic [7:0] rv;
        logic [31:0] r;
        do_reset(1'b0);
        host_u.read_reg(RATE_SELECT_ADDR, rv);
        check("reset_gnd", rv, RESET_BOOT_GND);
        host_u.write_reg(8'h18, 8'hFF);
        host_u.read_reg(RATE_SELECT_ADDR, rv);
        check("unmapped_write", rv, 8'h00);
        host_u.read_reg(8'h18, rv);
        check("unmapped_read", rv, 8'h00);
        run_case(PM_LOW_POWER, 4'h0, 12'd0, 1'b0);
        run_case(PM_HIGH_PERF, 4'h0, 12'd0, 1'b1);
        run_case(PM_HIGH_PERF, 4'h3, 12'd0, 1'b0);
        run_case(2'h2, 4'h2, 12'd0, 1'b1);
        run_case(2'h3, 4'h1, 12'h101, 1'b0);
        run_case(PM_HIGH_PERF, 4'hF, 12'd0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            run_case(r[1:0], {1'b0, r[6:4]}, 12'(r[9:8]), r[12]);
        end
        // slowest low-power code: decimation stays one
        host_u.write_reg(RATE_SELECT_ADDR, 8'hE0);
        set_state(1'b0, PM_LOW_POWER, 12'd0);
        host_u.set_active(1'b1);
        repeat (3) @(posedge clk);
        #1 check("slow_state", scheduler_state, 2'h1);
        check("slow_decim", decimation, 13'h1);
        host_u.set_active(1'b0);
        repeat (2) @(posedge clk);
        // awake to asleep switch in mid-run
        host_u.write_reg(RATE_SELECT_ADDR, 8'h21);
        set_state(1'b1, 2'h2, 12'd2);
        set_state(1'b0, PM_LOW_POWER, 12'd0);
        host_u.set_active(1'b1);
        wait_event(n);
        wait_event(n);
        @(posedge clk);
        asleep <= 1'b1;
        @(posedge clk);
        #1 check("gap_state", scheduler_state, 2'h2);
        wait_event(n);
        check("gap_len", n >= GAP - 1 && n <= GAP + 2, 1'b1);
        wait_event(n);
        check("new_period", n, 24);
        check("new_decim", decimation, 13'h2);
        // boot pin tied high: pulsed interrupt line
        do_reset(1'b1);
        host_u.read_reg(RATE_SELECT_ADDR, rv);
        check("reset_vdd", rv, RESET_BOOT_VDD);
        host_u.write_reg(RATE_SELECT_ADDR, 8'h50);
        set_state(1'b1, PM_LOW_POWER, 12'd0);
        set_state(1'b0, PM_LOW_POWER, 12'd0);
        ready_irq_enable <= 1'b1;
        host_u.set_active(1'b1);
        wait_event(n);
        @(posedge clk);
        #1 check("line_level", first_interrupt_out, 1'b0);
        k = 0;
        while (first_interrupt_oe_b === 1'b0 && k < 100) begin
            k++;
            @(posedge clk);
            #1;
        end
        check("pulse_width", k, PULSE);
        @(posedge clk);
        ready_irq_enable <= 1'b0;
        wait_event(n);
        @(posedge clk);
        #1 check("no_pulse", first_interrupt_oe_b, 1'b1);
        tally_and_finish();
    end
endmodule
